/* File: rtl/frpc_top.sv */
/*
 Flash rewrite protection control: mode entry at reset release, link
 selection by pulse count, serial byte transport, protection checks,
 flash operation sequencing with verify, and the instruction fetch port.
 Assumes a flash macro that answers each start pulse with exactly one done
 pulse, and a nonvolatile store whose flags are valid at reset release.
*/
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "frpc_params.svh"
module frpc_top #(
  parameter int BLOCKS = `FRPC_BLOCKS,
  parameter int PULSE_WIN_CYC = `FRPC_PULSE_WIN_US * (`FRPC_CLK_HZ / 1000000)
) (
  input logic clock,
  input logic rstn,
  input logic mode_select_pulse_pin,
  input logic mode_qualifier_pin,
  input logic serial_clock_pin,
  input logic serial_data_in_pin,
  output logic serial_data_out_pin,
  output logic handshake_pin,
  output logic prog_mode,
  output logic pins_hold_reset,
  output logic link_mode_err,
  input logic [3:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [31:0] reg_rdata,
  input logic fetch_req,
  input logic [18:0] fetch_addr,
  output logic [31:0] fetch_rdata,
  output logic fetch_valid,
  output logic fetch_refused,
  output logic [18:0] flash_raddr,
  input logic [31:0] flash_rdata,
  output frpc_pkg::frpc_flash_s flash_cmd,
  output logic flash_start,
  input logic flash_done,
  input logic flash_ok,
  input frpc_pkg::frpc_flags_s nv_flags_in,
  output frpc_pkg::frpc_flags_s nv_flags_out,
  output logic nv_flags_wr
);
  localparam int PW = $clog2(PULSE_WIN_CYC + 1);
  localparam int BIT_MIN = `FRPC_CLK_HZ / `FRPC_BAUD_MAX;
  localparam int BIT_MAX = `FRPC_CLK_HZ / `FRPC_BAUD_MIN;
  localparam logic [13:0] BIT_LO = 14'(BIT_MIN - BIT_MIN / 16);
  localparam logic [13:0] BIT_HI = 14'(BIT_MAX + BIT_MAX / 16);
  // 455/4096 approximates one ninth of the reset byte's low time
  localparam logic [25:0] NINTH = 26'h1C7;
  localparam logic [7:0] NBLK = 8'(BLOCKS);
  localparam logic [7:0] NBOOT = 8'(`FRPC_BOOT_BLOCKS);

  if (BLOCKS < `FRPC_BOOT_BLOCKS || BLOCKS > `FRPC_BLOCKS || PULSE_WIN_CYC < 2) begin : g_bad_param
    $error("frpc_top: BLOCKS or PULSE_WIN_CYC out of range");
  end

  // Pin synchronisers, order {data in, serial clock, qualifier, mode select}
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] p_r;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s1_r <= 4'hC;
      s2_r <= 4'hC;
      p_r <= 4'hC;
    end else begin
      s1_r <= {serial_data_in_pin, serial_clock_pin, mode_qualifier_pin, mode_select_pulse_pin};
      s2_r <= s1_r;
      p_r <= s2_r;
    end
  end
  logic msel;
  logic qual;
  logic sck;
  logic sdi;
  logic msel_fall;
  logic sck_rise;
  logic sck_fall;
  assign msel = s2_r[0];
  assign qual = s2_r[1];
  assign sck = s2_r[2];
  assign sdi = s2_r[3];
  assign msel_fall = p_r[0] & ~msel;
  assign sck_rise = ~p_r[2] & sck;
  assign sck_fall = p_r[2] & ~sck;

  // Link state: mode entry, pulse count, bit-rate measurement
  frpc_pkg::frpc_link_e ls_r;
  frpc_pkg::frpc_chan_e chan_r;
  logic [1:0] cap_cnt_r;
  logic prog_mode_r;
  logic [3:0] pulse_cnt_r;
  logic [PW-1:0] win_r;
  logic [16:0] low_r;
  logic [13:0] bit_r;
  logic baud_done_r;
  logic [25:0] est;
  logic [13:0] bit_est;
  logic cap_now;
  assign est = {9'h000, low_r} * NINTH;
  assign bit_est = est[25:12];
  assign cap_now = (ls_r == frpc_pkg::LS_BOOT) && (cap_cnt_r == 2'h3);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ls_r <= frpc_pkg::LS_BOOT;
      chan_r <= frpc_pkg::CH_NONE;
      cap_cnt_r <= 2'h0;
      prog_mode_r <= 1'b0;
      pulse_cnt_r <= 4'h0;
      win_r <= '0;
      low_r <= 17'h00000;
      bit_r <= 14'h0000;
      baud_done_r <= 1'b0;
    end else begin
      baud_done_r <= 1'b0;
      case (ls_r)
        frpc_pkg::LS_BOOT: begin
          // Pins sampled once the synchronisers hold released-reset levels
          cap_cnt_r <= cap_cnt_r + 2'h1;
          if (cap_now) begin
            prog_mode_r <= msel & ~qual; // [RULE23]
            ls_r <= (msel & ~qual) ? frpc_pkg::LS_PULSE : frpc_pkg::LS_NORMAL; // [RULE23]
          end
        end
        frpc_pkg::LS_PULSE: begin
          if (msel_fall) begin
            win_r <= '0;
            // Count saturates one past the limit so overflow stays visible
            if (pulse_cnt_r != 4'(`FRPC_MAX_PULSES + 1)) begin
              pulse_cnt_r <= pulse_cnt_r + 4'h1; // [RULE18]
            end
          end else if (win_r == PW'(PULSE_WIN_CYC - 1)) begin
            case (pulse_cnt_r)
              `FRPC_PULSES_ASYNC: begin
                chan_r <= frpc_pkg::CH_ASYNC; // [RULE22]
                ls_r <= frpc_pkg::LS_BAUD;
              end
              `FRPC_PULSES_CSI: begin
                chan_r <= frpc_pkg::CH_CSI; // [RULE22]
                ls_r <= frpc_pkg::LS_RUN;
              end
              `FRPC_PULSES_HS: begin
                chan_r <= frpc_pkg::CH_HS; // [RULE22]
                ls_r <= frpc_pkg::LS_RUN;
              end
              default: ls_r <= frpc_pkg::LS_ERR; // [RULE22]
            endcase
          end else begin
            win_r <= win_r + PW'(1);
          end
        end
        frpc_pkg::LS_BAUD: begin
          // Reset command is all zeros: start plus eight data bits low
          if (!sdi) begin
            if (low_r != 17'h1FFFF) begin
              low_r <= low_r + 17'h00001; // [RULE24]
            end
          end else if (low_r != 17'h00000) begin
            low_r <= 17'h00000;
            if (bit_est >= BIT_LO && bit_est <= BIT_HI) begin
              bit_r <= bit_est; // [RULE24] [RULE15]
              ls_r <= frpc_pkg::LS_RUN;
              baud_done_r <= 1'b1;
            end
          end
        end
        frpc_pkg::LS_NORMAL, frpc_pkg::LS_RUN, frpc_pkg::LS_ERR: ls_r <= ls_r;
        default: ls_r <= frpc_pkg::LS_BOOT;
      endcase
    end
  end

  // Byte receiver
  logic async_ch;
  logic run_ch;
  assign async_ch = (chan_r == frpc_pkg::CH_ASYNC);
  assign run_ch = (ls_r == frpc_pkg::LS_RUN);
  logic [7:0] rx_sh_r;
  logic [7:0] rx_byte_r;
  logic rx_v_r;
  logic rx_act_r;
  logic [3:0] rx_idx_r;
  logic [13:0] rx_tim_r;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rx_sh_r <= 8'h00;
      rx_byte_r <= 8'h00;
      rx_v_r <= 1'b0;
      rx_act_r <= 1'b0;
      rx_idx_r <= 4'h0;
      rx_tim_r <= 14'h0000;
    end else begin
      rx_v_r <= 1'b0;
      if (run_ch && !async_ch) begin
        if (sck_rise) begin
          rx_sh_r <= {rx_sh_r[6:0], sdi}; // [RULE16]
          rx_idx_r <= (rx_idx_r == 4'h7) ? 4'h0 : rx_idx_r + 4'h1;
          if (rx_idx_r == 4'h7) begin
            rx_byte_r <= {rx_sh_r[6:0], sdi};
            rx_v_r <= 1'b1;
          end
        end
      end else if (run_ch) begin
        if (!rx_act_r) begin
          if (!sdi) begin
            rx_act_r <= 1'b1;
            rx_tim_r <= {1'b0, bit_r[13:1]};
            rx_idx_r <= 4'h0;
          end
        end else if (rx_tim_r != 14'h0000) begin
          rx_tim_r <= rx_tim_r - 14'h0001;
        end else begin
          rx_tim_r <= bit_r - 14'h0001;
          rx_idx_r <= rx_idx_r + 4'h1;
          if (rx_idx_r == 4'h0) begin
            // A start bit gone high at mid-bit was a glitch
            rx_act_r <= ~sdi;
          end else if (rx_idx_r <= 4'h8) begin
            rx_sh_r <= {sdi, rx_sh_r[7:1]}; // [RULE22]
          end else begin
            rx_act_r <= 1'b0;
            rx_byte_r <= rx_sh_r;
            rx_v_r <= sdi;
          end
        end
      end
    end
  end

  // Command assembly: opcode byte, then argument byte
  logic ph_r;
  logic prog_go_r;
  logic cmd_bad_r;
  logic [2:0] cmd_op_r;
  logic [7:0] cmd_arg_r;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ph_r <= 1'b0;
      prog_go_r <= 1'b0;
      cmd_bad_r <= 1'b0;
      cmd_op_r <= 3'h0;
      cmd_arg_r <= 8'h00;
    end else begin
      prog_go_r <= 1'b0;
      if (run_ch && rx_v_r) begin
        ph_r <= ~ph_r;
        if (!ph_r) begin
          cmd_op_r <= rx_byte_r[2:0];
          cmd_bad_r <= |rx_byte_r[7:3];
        end else begin
          cmd_arg_r <= rx_byte_r;
          prog_go_r <= 1'b1;
        end
      end
    end
  end

  // Permission check against the flags in force
  function automatic logic frpc_allow(input frpc_pkg::frpc_op_e op, input logic [6:0] blk,
                                      input logic self_src, input frpc_pkg::frpc_flags_s fl);
    logic boot_hit;
    logic in_range;
    logic ok;
    boot_hit = fl.boot && ({1'b0, blk} < NBOOT); // [RULE2] [RULE14]
    in_range = {1'b0, blk} < NBLK; // [RULE1]
    case (op)
      frpc_pkg::FOP_BLANK: ok = in_range;
      frpc_pkg::FOP_ERASE_ALL: ok = !self_src && !fl.chip; // [RULE5] [RULE8]
      frpc_pkg::FOP_ERASE_BLK: ok = in_range && (self_src ? !boot_hit : !(fl.blk || fl.chip || fl.prog)); // [RULE7] [RULE8] [RULE9] [RULE13]
      frpc_pkg::FOP_WRITE: ok = in_range && (self_src ? !boot_hit : !fl.prog); // [RULE9] [RULE13] [RULE14]
      frpc_pkg::FOP_VERIFY, frpc_pkg::FOP_CSUM: ok = in_range && !self_src && !fl.rd; // [RULE5] [RULE10]
      frpc_pkg::FOP_READ: ok = in_range && (self_src || !fl.rd); // [RULE10] [RULE13]
      frpc_pkg::FOP_PROT: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Operation engine
  frpc_pkg::frpc_opst_e os_r;
  frpc_pkg::frpc_flags_s flags_r;
  frpc_pkg::frpc_op_e cur_op_r;
  frpc_pkg::frpc_op_e op_in;
  logic [6:0] cur_blk_r;
  logic [6:0] blk_in;
  logic [4:0] arg_in;
  logic src_self_r;
  logic flash_start_r;
  logic rsp_v_r;
  logic [7:0] rsp_r;
  logic res_ok_r;
  logic done_ev_r;
  logic ref_ev_r;
  logic nv_wr_r;
  logic ctrl_wr;
  logic go_self;
  logic allow;
  assign ctrl_wr = reg_wr && (reg_addr == `FRPC_REG_CTRL);
  assign go_self = ctrl_wr && reg_wdata[`FRPC_CTRL_START] && (ls_r == frpc_pkg::LS_NORMAL);
  assign op_in = go_self ? frpc_pkg::frpc_op_e'(reg_wdata[3:1]) : frpc_pkg::frpc_op_e'(cmd_op_r);
  assign blk_in = go_self ? reg_wdata[10:4] : cmd_arg_r[6:0];
  assign arg_in = go_self ? reg_wdata[20:16] : cmd_arg_r[4:0];
  assign allow = frpc_allow(op_in, blk_in, go_self, flags_r) && (go_self || !cmd_bad_r); // [RULE25]

  always_ff @(posedge clock) begin
    if (!rstn) begin
      os_r <= frpc_pkg::OS_IDLE;
      flags_r <= '0; // [RULE11]
      cur_op_r <= frpc_pkg::FOP_BLANK;
      cur_blk_r <= 7'h00;
      src_self_r <= 1'b0;
      flash_start_r <= 1'b0;
      rsp_v_r <= 1'b0;
      rsp_r <= 8'h00;
      res_ok_r <= 1'b0;
      done_ev_r <= 1'b0;
      ref_ev_r <= 1'b0;
      nv_wr_r <= 1'b0;
    end else begin
      flash_start_r <= 1'b0;
      rsp_v_r <= 1'b0;
      done_ev_r <= 1'b0;
      ref_ev_r <= 1'b0;
      nv_wr_r <= 1'b0;
      if (cap_now) begin
        flags_r <= nv_flags_in; // [RULE25]
      end
      if (baud_done_r) begin
        rsp_v_r <= 1'b1;
        rsp_r <= `FRPC_RSP_ACK;
      end
      case (os_r)
        frpc_pkg::OS_IDLE: begin
          if (go_self || prog_go_r) begin
            src_self_r <= go_self;
            cur_op_r <= op_in;
            cur_blk_r <= blk_in;
            if (!allow) begin
              ref_ev_r <= go_self;
              rsp_v_r <= !go_self;
              rsp_r <= `FRPC_RSP_NAK;
            end else if (op_in == frpc_pkg::FOP_PROT) begin
              // Flags set here or reloaded from nv_flags_in at cap_now, each bit on its own
              flags_r <= flags_r | arg_in; // [RULE12] [RULE14]
              nv_wr_r <= 1'b1; // [RULE25]
              done_ev_r <= go_self;
              rsp_v_r <= !go_self;
              rsp_r <= `FRPC_RSP_ACK;
            end else begin
              flash_start_r <= 1'b1;
              os_r <= frpc_pkg::OS_RUN;
            end
          end
        end
        frpc_pkg::OS_RUN: begin
          if (flash_done) begin
            if (cur_op_r == frpc_pkg::FOP_WRITE && flash_ok) begin
              cur_op_r <= frpc_pkg::FOP_VERIFY; // [RULE6]
              flash_start_r <= 1'b1; // [RULE6]
              os_r <= frpc_pkg::OS_VER;
            end else begin
              res_ok_r <= flash_ok; // [RULE21]
              os_r <= frpc_pkg::OS_END;
            end
          end
        end
        frpc_pkg::OS_VER: begin
          if (flash_done) begin
            res_ok_r <= flash_ok; // [RULE6]
            os_r <= frpc_pkg::OS_END;
          end
        end
        frpc_pkg::OS_END: begin
          os_r <= frpc_pkg::OS_IDLE;
          if (cur_op_r == frpc_pkg::FOP_ERASE_ALL && res_ok_r) begin
            flags_r <= '{chip: flags_r.chip, default: 1'b0}; // [RULE7] [RULE9] [RULE11] [RULE8]
            nv_wr_r <= 1'b1;
          end
          done_ev_r <= src_self_r;
          rsp_v_r <= !src_self_r;
          rsp_r <= res_ok_r ? `FRPC_RSP_ACK : `FRPC_RSP_FAIL; // [RULE21]
        end
        default: os_r <= frpc_pkg::OS_IDLE;
      endcase
      // A command landing mid-operation is turned away, never queued
      if (os_r != frpc_pkg::OS_IDLE) begin
        ref_ev_r <= go_self;
        if (prog_go_r) begin
          rsp_v_r <= 1'b1;
          rsp_r <= `FRPC_RSP_NAK;
        end
      end
    end
  end
  assign flash_cmd = '{op: cur_op_r, block: cur_blk_r};
  assign flash_start = flash_start_r;
  assign nv_flags_out = flags_r;
  assign nv_flags_wr = nv_wr_r;

  // Byte transmitter
  logic [7:0] tx_sh_r;
  logic [9:0] utx_r;
  logic [3:0] tx_idx_r;
  logic [13:0] tx_tim_r;
  logic tx_busy_r;
  logic sdo_r;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      tx_sh_r <= 8'hFF;
      utx_r <= 10'h3FF;
      tx_idx_r <= 4'h0;
      tx_tim_r <= 14'h0000;
      tx_busy_r <= 1'b0;
      sdo_r <= 1'b1;
    end else begin
      sdo_r <= async_ch ? utx_r[0] : tx_sh_r[7];
      if (rsp_v_r && async_ch) begin
        utx_r <= {1'b1, rsp_r, 1'b0};
        tx_busy_r <= 1'b1;
        tx_idx_r <= 4'h0;
        tx_tim_r <= bit_r - 14'h0001;
      end else if (rsp_v_r) begin
        tx_sh_r <= rsp_r;
      end else if (!async_ch && sck_fall) begin
        tx_sh_r <= {tx_sh_r[6:0], 1'b1}; // [RULE16]
      end else if (tx_busy_r) begin
        if (tx_tim_r != 14'h0000) begin
          tx_tim_r <= tx_tim_r - 14'h0001;
        end else begin
          tx_tim_r <= bit_r - 14'h0001;
          utx_r <= {1'b1, utx_r[9:1]}; // [RULE22]
          tx_idx_r <= tx_idx_r + 4'h1;
          tx_busy_r <= (tx_idx_r != 4'h9);
        end
      end
    end
  end

  // Handshake: high while a new command may be clocked in
  logic hs_r;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      hs_r <= 1'b0;
    end else begin
      hs_r <= (chan_r == frpc_pkg::CH_HS) && run_ch && (os_r == frpc_pkg::OS_IDLE) && !prog_go_r; // [RULE17]
    end
  end
  assign serial_data_out_pin = sdo_r;
  assign handshake_pin = hs_r;
  assign prog_mode = prog_mode_r;
  assign pins_hold_reset = prog_mode_r; // [RULE19]
  assign link_mode_err = (ls_r == frpc_pkg::LS_ERR);

  // Fetch port: pipelined, one 32-bit word per clock
  logic self_busy;
  logic [18:0] raddr_r;
  logic fv1_r;
  logic fv2_r;
  logic fref_r;
  logic [31:0] frd_r;
  assign self_busy = src_self_r && (os_r != frpc_pkg::OS_IDLE);
  // Interrupt logic is untouched here; only flash-resident code stalls [RULE20]
  always_ff @(posedge clock) begin
    if (!rstn) begin
      raddr_r <= 19'h00000;
      fv1_r <= 1'b0;
      fv2_r <= 1'b0;
      fref_r <= 1'b0;
      frd_r <= 32'h00000000;
    end else begin
      raddr_r <= fetch_addr;
      fv1_r <= fetch_req && !self_busy; // [RULE4]
      fref_r <= fetch_req && self_busy; // [RULE4]
      fv2_r <= fv1_r;
      frd_r <= flash_rdata; // [RULE3]
    end
  end
  assign flash_raddr = raddr_r;
  assign fetch_rdata = frd_r;
  assign fetch_valid = fv2_r;
  assign fetch_refused = fref_r;

  // Register port
  logic done_r;
  logic refused_r;
  logic [2:0] c_op_r;
  logic [6:0] c_blk_r;
  logic [4:0] c_arg_r;
  logic [31:0] rd_r;
  logic stat_w1c;
  assign stat_w1c = reg_wr && (reg_addr == `FRPC_REG_STAT);
  always_ff @(posedge clock) begin
    if (!rstn) begin
      done_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      // Set beats a simultaneous software clear
      done_r <= done_ev_r || (done_r && !(stat_w1c && reg_wdata[`FRPC_STAT_DONE]));
      refused_r <= ref_ev_r || (refused_r && !(stat_w1c && reg_wdata[`FRPC_STAT_REFUSED]));
    end
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      c_op_r <= 3'h0;
      c_blk_r <= 7'h00;
      c_arg_r <= 5'h00;
    end else if (ctrl_wr) begin
      c_op_r <= reg_wdata[3:1];
      c_blk_r <= reg_wdata[10:4];
      c_arg_r <= reg_wdata[20:16];
    end
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rd_r <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `FRPC_REG_CTRL: rd_r <= {11'h000, c_arg_r, 5'h00, c_blk_r, c_op_r, 1'b0};
        `FRPC_REG_STAT: rd_r <= {24'h000000, link_mode_err, chan_r, prog_mode_r, res_ok_r, refused_r, done_r,
                                 os_r != frpc_pkg::OS_IDLE};
        `FRPC_REG_PROT: rd_r <= {27'h0000000, flags_r};
        default: rd_r <= 32'h00000000;
      endcase
    end else begin
      rd_r <= 32'h00000000;
    end
  end
  assign reg_rdata = rd_r;
endmodule : frpc_top

/* File: rtl/frpc_params.svh */
/*
 Constants of the flash rewrite protection control block: geometry, link
 selection, bit-rate limits, register map, command and answer codes.
 Assumes a 100 MHz system clock and a link layer that carries one opcode
 byte and one argument byte for each command.
*/
// Overview of operation
// [RULE1] Flash is 4 KB blocks, 128 blocks; erase per block or all at once.
// [RULE2] Lowest sixteen blocks form a boot cluster with separate write protection.
// [RULE3] Instruction fetch delivers four bytes of flash each clock.
// [RULE4] Flash fetches and data accesses are refused during a self-programming rewrite.
// [RULE5] Chip erase and verify/checksum only over the programmer link, not self-programming.
// [RULE6] Every write is followed by a verify of the write level; a write that ends with flash_ok low gets no verify.
// [RULE7] Block-erase prohibit rejects programmer block erase; chip erase clears it.
// [RULE8] Chip-erase prohibit rejects block and chip erase; never cleared.
// [RULE9] Program prohibit rejects programmer write and block erase; chip erase clears it.
// [RULE10] Read prohibit rejects programmer commands that return flash contents.
// [RULE11] Flags start clear; programmer chip erase clears every clearable flag.
// [RULE12] Flags are set independently and each enforces its own limits.
// [RULE13] Programmer prohibit flags never restrict self-programming.
// [RULE14] A boot protect flag blocks self-programming changes to the boot cluster.
// [RULE15] Async channel runs between 9,600 and 153,600 bps.
// [RULE16] Clocked modes: programmer clock 2.4 kHz to 2.5 MHz, MSB first.
// [RULE17] Clocked mode with handshake drives a handshake pin to the programmer.
// [RULE18] After mode entry, pulses on the mode-select pin are counted, eleven at most.
// [RULE19] In programming mode unused pins stay in their reset state.
// [RULE20] Interrupts stay serviced during a self-programming rewrite.
// [RULE21] Blank check reports whether the addressed block is fully erased.
// [RULE22] Zero pulses async LSB first, eight clocked slave, eleven handshake, else prohibited.
// [RULE23] Mode-select high with qualifier low at reset release enters programming mode.
// [RULE24] Async bit timing is derived from the programmer's reset command.
// [RULE25] Flags are nonvolatile and are checked before each programmer command.
`ifndef FRPC_PARAMS_SVH
`define FRPC_PARAMS_SVH
`define FRPC_CLK_HZ 100000000
`define FRPC_BLK_BYTES 4096
`define FRPC_BLOCKS 128
`define FRPC_BOOT_BLOCKS 16
`define FRPC_MAX_PULSES 11
`define FRPC_PULSES_ASYNC 4'h0
`define FRPC_PULSES_CSI 4'h8
`define FRPC_PULSES_HS 4'hB
`define FRPC_PULSE_WIN_US 1000
`define FRPC_BAUD_MIN 9600
`define FRPC_BAUD_MAX 153600
`define FRPC_SCK_MIN_HZ 2400
`define FRPC_SCK_MAX_HZ 2500000
`define FRPC_RESET_LOW_BITS 9
`define FRPC_REG_CTRL 4'h0
`define FRPC_REG_STAT 4'h4
`define FRPC_REG_PROT 4'h8
`define FRPC_CTRL_START 0
`define FRPC_STAT_DONE 1
`define FRPC_STAT_REFUSED 2
`define FRPC_RSP_ACK 8'h06
`define FRPC_RSP_NAK 8'h15
`define FRPC_RSP_FAIL 8'h1B
`endif

/* File: rtl/frpc_pkg.sv */
/*
 Types of the flash rewrite protection control block.
 Assumes the constants header is compiled alongside.
*/
package frpc_pkg;
  typedef enum logic [2:0] {
    FOP_BLANK = 3'h0, FOP_ERASE_ALL = 3'h1, FOP_ERASE_BLK = 3'h2, FOP_WRITE = 3'h3,
    FOP_VERIFY = 3'h4, FOP_CSUM = 3'h5, FOP_READ = 3'h6, FOP_PROT = 3'h7
  } frpc_op_e;
  typedef enum logic [1:0] {CH_NONE = 2'h0, CH_ASYNC = 2'h1, CH_CSI = 2'h2, CH_HS = 2'h3} frpc_chan_e;
  typedef enum logic [5:0] {
    LS_BOOT = 6'h01, LS_NORMAL = 6'h02, LS_PULSE = 6'h04, LS_BAUD = 6'h08, LS_RUN = 6'h10, LS_ERR = 6'h20
  } frpc_link_e;
  typedef enum logic [3:0] {OS_IDLE = 4'h1, OS_RUN = 4'h2, OS_VER = 4'h4, OS_END = 4'h8} frpc_opst_e;
  typedef struct packed {
    logic boot;
    logic rd;
    logic prog;
    logic chip;
    logic blk;
  } frpc_flags_s;
  typedef struct packed {
    frpc_op_e op;
    logic [6:0] block;
  } frpc_flash_s;
endpackage : frpc_pkg

/* File: verification/frpc_props.sv */
/* Port checker for frpc_top.
   Assumes binding to every frpc_top instance; sees its ports only. */
`timescale 1ns/1ns
module frpc_props (
  input logic clock,
  input logic rstn,
  input logic handshake_pin,
  input logic prog_mode,
  input logic pins_hold_reset,
  input logic link_mode_err,
  input logic fetch_req,
  input logic [31:0] fetch_rdata,
  input logic fetch_valid,
  input logic fetch_refused,
  input logic [31:0] flash_rdata,
  input frpc_pkg::frpc_flash_s flash_cmd,
  input logic flash_start,
  input logic flash_done,
  input logic flash_ok
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_write_ok;
    flash_done && flash_ok && flash_cmd.op == frpc_pkg::FOP_WRITE;
  endsequence
  sequence s_verify_go;
    flash_start && flash_cmd.op == frpc_pkg::FOP_VERIFY;
  endsequence
  sequence s_self_busy;
    flash_start && !prog_mode ##1 fetch_req;
  endsequence
  a_write_then_verify: assert property (s_write_ok |=> s_verify_go)
    else $error("write not followed by verify");
  a_fetch_answer: assert property (fetch_req |-> ##1 fetch_refused or ##2 fetch_valid)
    else $error("fetch not answered in time");
  a_fetch_data: assert property (fetch_valid |-> fetch_rdata == $past(flash_rdata))
    else $error("fetch word differs from array");
  a_fetch_lock: assert property (s_self_busy |=> fetch_refused)
    else $error("fetch served during rewrite");
  a_pins_hold: assert property (pins_hold_reset == prog_mode)
    else $error("pin hold differs from mode");
  a_self_no_chip: assert property (!prog_mode && flash_start |->
    !(flash_cmd.op inside {frpc_pkg::FOP_ERASE_ALL, frpc_pkg::FOP_CSUM}))
    else $error("self op not allowed started");
  a_hs_mode_only: assert property (!prog_mode |-> !handshake_pin)
    else $error("handshake driven outside mode");
  a_err_prog_only: assert property (link_mode_err |-> prog_mode)
    else $error("mode error outside programming");
endmodule : frpc_props
bind frpc_top frpc_props u_frpc_props (.clock, .rstn, .handshake_pin, .prog_mode, .pins_hold_reset,
  .link_mode_err, .fetch_req, .fetch_rdata, .fetch_valid, .fetch_refused, .flash_rdata, .flash_cmd,
  .flash_start, .flash_done, .flash_ok);

/* File: verification/frpc_prog_model.sv */
/* Programmer model: mode pins and idle serial lines.
   Assumes the bench's clock; no frames are sent, so the serial clock stands still. */
`timescale 1ns/1ns
module frpc_prog_model (
  input logic clock,
  output logic mode_select_pulse_pin,
  output logic mode_qualifier_pin,
  output logic serial_clock_pin,
  output logic serial_data_in_pin
);
  initial begin
    mode_select_pulse_pin = 1'b0;
    mode_qualifier_pin = 1'b0;
    serial_clock_pin = 1'b1;
    serial_data_in_pin = 1'b1;
  end
  task automatic enter(input logic prog);
    @(posedge clock) mode_select_pulse_pin <= prog;
  endtask : enter
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clock) mode_select_pulse_pin <= 1'b0;
      repeat (5) @(posedge clock);
      mode_select_pulse_pin <= 1'b1;
      repeat (5) @(posedge clock);
    end
  endtask : pulses
endmodule : frpc_prog_model

/* File: verification/frpc_top_bench.sv */
/* Self-checking bench for frpc_top.
   Assumes flash macro and flag store are modelled here; programmer by frpc_prog_model. */
`timescale 1ns/1ns
`include "frpc_params.svh"
module frpc_top_bench;
  logic clock = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic fetch_req = 1'b0, fetch_on = 1'b0, flash_done = 1'b0, flash_start;
  logic ms, mq, sck, sdi, sdo, hs, pm, phr, lme, fv, fr, nvw;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, fetch_rdata, flash_rdata, exp_q[$];
  logic [18:0] fetch_addr = 19'h0, flash_raddr;
  frpc_pkg::frpc_flash_s flash_cmd;
  frpc_pkg::frpc_flags_s nv_store = '0, nv_out;
  logic [6:0] blk_t[5] = '{7'h14, 7'h14, 7'h03, 7'h00, 7'h14};
  logic [2:0] op_t[5] = '{3'h2, 3'h3, 3'h2, 3'h1, 3'h5};
  int go_t[5] = '{1, 2, 0, 0, 0}, pc_t[4] = '{0, 8, 11, 3};
  logic [31:0] st_t[4] = '{32'h30, 32'h50, 32'h70, 32'h90};
  int fails = 0, checks = 0, starts = 0, n = 0;
  always #5 clock = ~clock;
  assign flash_rdata = {13'h0AC, flash_raddr};
  frpc_prog_model u_frpc_prog_model (.clock(clock), .mode_select_pulse_pin(ms), .mode_qualifier_pin(mq),
    .serial_clock_pin(sck), .serial_data_in_pin(sdi));
  frpc_top #(.PULSE_WIN_CYC(200)) u_frpc_top (.clock(clock), .rstn(rstn), .mode_select_pulse_pin(ms),
    .mode_qualifier_pin(mq), .serial_clock_pin(sck), .serial_data_in_pin(sdi), .serial_data_out_pin(sdo),
    .handshake_pin(hs), .prog_mode(pm), .pins_hold_reset(phr), .link_mode_err(lme), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_rdata(fetch_rdata), .fetch_valid(fv), .fetch_refused(fr),
    .flash_raddr(flash_raddr), .flash_rdata(flash_rdata), .flash_cmd(flash_cmd), .flash_start(flash_start),
    .flash_done(flash_done), .flash_ok(1'b1), .nv_flags_in(nv_store), .nv_flags_out(nv_out), .nv_flags_wr(nvw));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // Flash macro answers next cycle; flags survive resets in the store
  always @(posedge clock) begin
    flash_done <= flash_start;
    if (flash_start) starts <= starts + 1;
    if (nvw) nv_store <= nv_out;
    fetch_req <= fetch_on && $urandom_range(1);
    fetch_addr <= 19'($urandom());
    rd_d <= reg_rd;
    if (rd_d) check("reg_rdata", reg_rdata, exp_q.pop_front());
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock) begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
    end
    @(posedge clock) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock) begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
    end
    @(posedge clock) reg_rd <= 1'b0;
  endtask : rd
  task automatic do_reset(input logic prog);
    u_frpc_prog_model.enter(prog);
    rstn <= 1'b0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (8) @(posedge clock);
  endtask : do_reset
  initial begin
    #300000;
    fails++;
    report_and_stop();
  end
  initial begin
    void'($urandom(45));
    do_reset(1'b0);
    rd(`FRPC_REG_STAT, 32'h0);
    rd(`FRPC_REG_PROT, 32'h0);
    rd(4'hC, 32'h0);
    wr(`FRPC_REG_CTRL, 32'h001F_000F);
    repeat (20) @(posedge clock);
    rd(`FRPC_REG_PROT, 32'h1F);
    $display("flag setting test done");
    fetch_on <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      n = starts;
      wr(`FRPC_REG_CTRL, {21'h0, blk_t[i], op_t[i], 1'b1});
      repeat (20) @(posedge clock);
      check("flash_start count", 32'(starts - n), 32'(go_t[i]));
    end
    fetch_on <= 1'b0;
    $display("self programming test done");
    for (int i = 0; i < 4; i++) begin
      do_reset(1'b1);
      u_frpc_prog_model.pulses(pc_t[i]);
      repeat (250) @(posedge clock);
      rd(`FRPC_REG_STAT, st_t[i]);
      check("handshake_pin", 32'(hs), 32'(pc_t[i] == 11));
      check("serial_data_out_pin", 32'(sdo), 32'h1);
      rd(`FRPC_REG_PROT, 32'h1F);
    end
    repeat (4) @(posedge clock);
    $display("link selection test done");
    report_and_stop();
  end
endmodule : frpc_top_bench
